/* core/lsd_defines.svh */
// Offsets, field positions, reset values and timing counts of the LED sink driver core
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LSD_OFS_IRQ_STATUS 8'h00
`define LSD_OFS_IRQ_CLEAR 8'h04
`define LSD_OFS_IRQ_ENABLE 8'h08
`define LSD_OFS_STORAGE 8'h0c
`define LSD_OFS_MODE 8'h10

// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define LSD_EV_LATCH 0
`define LSD_EV_DETECT 1
`define LSD_EV_FAULT 2
`define LSD_EV_THERMAL 3
`define LSD_EV_WIDTH 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSD_RST_EV 4'h0
`define LSD_RST_DATA 24'h000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSD_CLK_PERIOD_NS 25
`define LSD_STAGGER_STEP_NS 50
`define LSD_STAGGER_STEP_CYC ((`LSD_STAGGER_STEP_NS + `LSD_CLK_PERIOD_NS - 1) / `LSD_CLK_PERIOD_NS)

`endif

/* core/lsd_pkg.sv */
// Types shared by the LED sink driver core
package lsd_pkg;
  typedef enum logic {LSD_NORMAL, LSD_DETECT} lsd_mode_type;
  typedef logic [2:0][7:0] lsd_bank_type;
endpackage

/* core/lsd_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module lsd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign sync = sync_q;
endmodule // lsd_sync

/* core/lsd_stagger.sv */
// Gradual turn-on mask for one group of eight sinks
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_stagger #(
  parameter int BASE = 0,
  parameter int STEP = `LSD_STAGGER_STEP_CYC,
  parameter int CW = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic group_on,
  input wire logic gradual,
  output logic [7:0] mask
);
  localparam logic [CW-1:0] CMAX = '1;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [7:0] mask_d;

  always_comb begin
    count_d = count_q;
    if (!group_on) begin
      count_d = '0;
    end else if (count_q != CMAX) begin
      count_d = count_q + 1'b1;
    end
    for (int k = 0; k < 8; k++) begin
      mask_d[k] = !gradual || (int'(count_q) >= (BASE + k) * STEP);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign mask = mask_d;

  a_stagger_late: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(group_on) && gradual |-> !mask[7])
    else $error("last sink of group turned on without delay");
endmodule // lsd_stagger

/* core/lsd_top.sv */
// LED sink driver core: shift chain, storage, detection, flags and AHB-Lite status port
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "lsd_defines.svh"

// Overview of operation
// - Serial data fills a 24-bit shift chain built from three groups of eight bits.
// - A separate 24-bit storage register takes the chain contents and, gated by the group enables and the turn-on mask, decides which sinks are driven.
// - Two flow pins pick the order the data takes through the three groups, held steady by the host while shifting.
// - With the gradual pin set, sinks switch on one after another with a fixed step instead of all at once.
// - Detection mode checks each output for short to ground, short to the output supply and open line.
// - Detection results replace the shift chain contents so further serial clocks move them out.
// - Detection mode is entered by its pin or by a pin sequence, and a like sequence returns to normal mode.
// - Each of the red, green and blue groups has an enable that gates only its own eight sinks.
// - In normal mode a latch pulse from the host copies all 24 chain bits into storage at once.
// - Output faults found by a latch in detection mode pull the open-drain error flag low and overtemperature pulls the thermal flag low.
// - The host clocks one bit in per serial clock and the serial output lets devices cascade.
module lsd_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic latch_strobe,
  input wire logic detect_mode_pin,
  input wire logic red_group_enable_n,
  input wire logic green_group_enable_n,
  input wire logic blue_group_enable_n,
  input wire logic gradual_turn_on,
  input wire logic flow_select_0,
  input wire logic flow_select_1,
  input wire logic [23:0] fault_short_gnd,
  input wire logic [23:0] fault_short_supply,
  input wire logic [23:0] fault_open,
  input wire logic over_temp,
  output logic [23:0] sink_on,
  output logic error_flag_o,
  output logic error_flag_oe,
  output logic thermal_flag_o,
  output logic thermal_flag_oe,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [10:0] ctl_s;
  logic [71:0] flt_s;
  logic sclk_s;
  logic sin_s;
  logic latch_s;
  logic dm_pin_s;
  logic [2:0] en_n_s;
  logic gradual_s;
  logic [1:0] flow_s;
  logic otemp_s;

  lsd_sync #(.WIDTH(11)) u_sync_ctl (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin({over_temp, flow_select_1, flow_select_0, gradual_turn_on, blue_group_enable_n,
          green_group_enable_n, red_group_enable_n, detect_mode_pin, latch_strobe, serial_in, serial_clk}),
    .sync(ctl_s)
  );

  // Fault comparators are asynchronous to the core clock
  lsd_sync #(.WIDTH(72)) u_sync_flt (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin({fault_open, fault_short_supply, fault_short_gnd}),
    .sync(flt_s)
  );

  assign sclk_s = ctl_s[0];
  assign sin_s = ctl_s[1];
  assign latch_s = ctl_s[2];
  assign dm_pin_s = ctl_s[3];
  assign en_n_s = ctl_s[6:4];
  assign gradual_s = ctl_s[7];
  assign flow_s = ctl_s[9:8];
  assign otemp_s = ctl_s[10];

  // ----------------------------------------
  // Flow order
  // ----------------------------------------
  // Group index held at chain position p: 0 red, 1 green, 2 blue
  function automatic logic [1:0] grp_at(input logic [1:0] fs, input int p);
    logic [1:0] g;
    g = 2'h0;
    case (fs)
      2'h0: g = (p == 0) ? 2'h0 : (p == 1) ? 2'h1 : 2'h2;
      2'h1: g = (p == 0) ? 2'h1 : (p == 1) ? 2'h2 : 2'h0;
      2'h2: g = (p == 0) ? 2'h2 : (p == 1) ? 2'h0 : 2'h1;
      default: g = (p == 0) ? 2'h0 : (p == 1) ? 2'h2 : 2'h1;
    endcase
    return g;
  endfunction

  // ----------------------------------------
  // Link state: edges, chain, storage, mode
  // ----------------------------------------
  lsd_pkg::lsd_bank_type sr_q, sr_d;
  logic [23:0] store_q, store_d;
  logic [23:0] results;
  lsd_pkg::lsd_mode_type cmd_mode_q, cmd_mode_d;
  logic sclk_prev_q, latch_prev_q, red_prev_q;
  logic sclk_rise, latch_rise, red_fall;
  logic detect_on, det_load, cmd_toggle;
  logic serial_out_q, serial_out_d;
  logic fault_q, fault_d;
  logic [23:0] sink_q, sink_d;
  logic [23:0] stag_mask;

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign latch_rise = latch_s && !latch_prev_q;
  assign red_fall = !en_n_s[0] && red_prev_q;
  assign detect_on = dm_pin_s || (cmd_mode_q == lsd_pkg::LSD_DETECT);
  // Sequence: red enable pulled low while latch is held high
  assign cmd_toggle = latch_s && red_fall;
  assign det_load = detect_on && latch_rise;

  for (genvar i = 0; i < 24; i++) begin : g_res
    assign results[i] = flt_s[i] | flt_s[24 + i] | flt_s[48 + i];
  end

  always_comb begin
    sr_d = sr_q;
    store_d = store_q;
    cmd_mode_d = cmd_mode_q;
    fault_d = fault_q;
    if (cmd_toggle) begin
      cmd_mode_d = (cmd_mode_q == lsd_pkg::LSD_NORMAL) ? lsd_pkg::LSD_DETECT : lsd_pkg::LSD_NORMAL;
    end
    if (det_load) begin
      sr_d = results;
      fault_d = |results;
    end else if (sclk_rise) begin
      for (int p = 0; p < 3; p++) begin
        sr_d[grp_at(flow_s, p)] = {sr_q[grp_at(flow_s, p)][6:0],
                                   (p == 0) ? sin_s : sr_q[grp_at(flow_s, p - 1)][7]};
      end
    end
    // Storage frozen in detection so lamps keep their pattern
    if (latch_rise && !detect_on) begin
      store_d = sr_q;
    end
    serial_out_d = sr_q[grp_at(flow_s, 2)][7];
    for (int i = 0; i < 24; i++) begin
      sink_d[i] = store_q[i] && !en_n_s[i / 8] && stag_mask[i];
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_stag
    lsd_stagger #(.BASE(8 * g)) u_stag (
      .clk_sys(clk_sys),
      .reset(reset),
      .group_on(!en_n_s[g]),
      .gradual(gradual_s),
      .mask(stag_mask[8 * g +: 8])
    );
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sr_q <= `LSD_RST_DATA;
      store_q <= `LSD_RST_DATA;
      cmd_mode_q <= lsd_pkg::LSD_NORMAL;
      sclk_prev_q <= 1'b0;
      latch_prev_q <= 1'b0;
      red_prev_q <= 1'b0;
      serial_out_q <= 1'b0;
      fault_q <= 1'b0;
      sink_q <= `LSD_RST_DATA;
    end else begin
      sr_q <= sr_d;
      store_q <= store_d;
      cmd_mode_q <= cmd_mode_d;
      sclk_prev_q <= sclk_s;
      latch_prev_q <= latch_s;
      red_prev_q <= en_n_s[0];
      serial_out_q <= serial_out_d;
      fault_q <= fault_d;
      sink_q <= sink_d;
    end
  end

  assign serial_out = serial_out_q;
  assign sink_on = sink_q;
  // Open-drain flags: only ever pull low
  assign error_flag_o = 1'b0;
  assign error_flag_oe = fault_q;
  assign thermal_flag_o = 1'b0;
  assign thermal_flag_oe = otemp_s;

  // ----------------------------------------
  // Events and register port
  // ----------------------------------------
  logic [3:0] ev;
  logic [3:0] stat_q, stat_d, ien_q, ien_d;
  logic otemp_prev_q;
  logic [7:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic [31:0] rdata_q, rdata_d;
  logic take;

  assign ev[`LSD_EV_LATCH] = latch_rise && !detect_on;
  assign ev[`LSD_EV_DETECT] = det_load;
  assign ev[`LSD_EV_FAULT] = det_load && (|results);
  assign ev[`LSD_EV_THERMAL] = otemp_s && !otemp_prev_q;
  assign take = hsel && hready && htrans[1];

  always_comb begin
    addr_d = addr_q;
    wr_d = 1'b0;
    rdata_d = rdata_q;
    stat_d = stat_q;
    ien_d = ien_q;
    if (take) begin
      addr_d = haddr;
      wr_d = hwrite;
      case (haddr)
        `LSD_OFS_IRQ_STATUS: rdata_d = {28'h0000000, stat_q};
        `LSD_OFS_IRQ_ENABLE: rdata_d = {28'h0000000, ien_q};
        `LSD_OFS_STORAGE: rdata_d = {8'h00, store_q};
        `LSD_OFS_MODE: rdata_d = {28'h0000000, flow_s, dm_pin_s, detect_on};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr_q && addr_q == `LSD_OFS_IRQ_CLEAR) begin
      stat_d = stat_q & ~hwdata[3:0];
    end
    if (wr_q && addr_q == `LSD_OFS_IRQ_ENABLE) begin
      ien_d = hwdata[3:0];
    end
    // Hardware set wins over a clear in the same cycle
    stat_d = stat_d | ev;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rdata_q <= 32'h00000000;
      stat_q <= `LSD_RST_EV;
      ien_q <= `LSD_RST_EV;
      otemp_prev_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wr_q <= wr_d;
      rdata_q <= rdata_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      otemp_prev_q <= otemp_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign irq = |(stat_q & ien_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cmd_seq;
    latch_s && red_fall;
  endsequence

  sequence s_detect_latch;
    detect_on && latch_rise;
  endsequence

  a_latch_copy: assert property (latch_rise && !detect_on |=> store_q == $past(sr_q))
    else $error("latch did not copy the chain into storage");
  a_storage_hold: assert property (!latch_rise |=> store_q == $past(store_q))
    else $error("storage changed without a latch");
  a_chain_entry: assert property (sclk_rise && !det_load |=>
    sr_q[grp_at($past(flow_s), 0)][0] == $past(sin_s))
    else $error("serial input not shifted into chain head");
  a_chain_link: assert property (sclk_rise && !det_load && $stable(flow_s) |=>
    sr_q[grp_at($past(flow_s), 1)][0] == $past(sr_q[grp_at(flow_s, 0)][7]))
    else $error("chain link between groups broken");
  a_serial_tail: assert property ($stable(flow_s) |=> serial_out == $past(sr_q[grp_at(flow_s, 2)][7]))
    else $error("serial output not the chain tail");
  a_detect_load: assert property (s_detect_latch |=> sr_q == $past(results))
    else $error("detection results not loaded");
  a_detect_flag: assert property (s_detect_latch |=>
    (error_flag_oe == $past(|results)) ##1 $stable(error_flag_oe))
    else $error("error flag not pulled low on fault");
  a_mode_toggle: assert property (s_cmd_seq |=> cmd_mode_q != $past(cmd_mode_q))
    else $error("command sequence did not toggle mode");
  a_group_gate: assert property (en_n_s[1] |=> sink_on[15:8] == 8'h00)
    else $error("green sinks on while group disabled");
  a_sink_needs_bit: assert property (sink_on[1] |-> $past(store_q[1]) && !$past(en_n_s[0]))
    else $error("sink on without storage bit and low enable");
  a_thermal_flag: assert property (thermal_flag_oe == $past(over_temp, 2))
    else $error("thermal flag not pulled low");
endmodule // lsd_top

/* tb/lsd_host_model.sv */
// Host model driving the serial link of the LED sink driver
`timescale 1ns/1ps
module lsd_host_model (
  output logic serial_clk,
  output logic serial_in,
  output logic latch_strobe,
  input wire logic serial_out
);
  // ----------------------------------------
  // Idle link
  // ----------------------------------------
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b1;
    latch_strobe = 1'b0;
  end

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Clock stands low between frames; data moves mid-low so it is steady around each rise
  task automatic shift24(input logic [23:0] v, output logic [23:0] seen);
    for (int k = 23; k >= 0; k--) begin
      #50 serial_in = v[k];
      #50 seen[k] = serial_out;
      serial_clk = 1'b1;
      #100 serial_clk = 1'b0;
    end
    // Released data line must not keep its last value
    #50 serial_in = ~serial_in;
  endtask

  task automatic pulse_latch();
    #60 latch_strobe = 1'b1;
    #100 latch_strobe = 1'b0;
    #200;
  endtask

  task automatic set_latch(input logic lvl);
    #60 latch_strobe = lvl;
    #100;
  endtask
endmodule // lsd_host_model

/* tb/lsd_top_tb.sv */
// Self-checking testbench of the LED sink driver core
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_top_tb;
  logic clk_sys, reset, serial_clk, serial_in, serial_out, latch_strobe, detect_mode_pin;
  logic red_group_enable_n, green_group_enable_n, blue_group_enable_n, gradual_turn_on;
  logic flow_select_0, flow_select_1, over_temp, error_flag_oe, thermal_flag_oe;
  logic [23:0] fault_short_gnd, fault_short_supply, fault_open, sink_on, seen;
  logic hsel, hwrite, hreadyout, irq, error_flag_o, thermal_flag_o, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [23:0] PATTERN = 24'h5a3c96;

  lsd_top i_dut (
    .clk_sys, .reset, .serial_clk, .serial_in, .serial_out, .latch_strobe, .detect_mode_pin,
    .red_group_enable_n, .green_group_enable_n, .blue_group_enable_n, .gradual_turn_on,
    .flow_select_0, .flow_select_1, .fault_short_gnd, .fault_short_supply, .fault_open,
    .over_temp, .sink_on, .error_flag_o, .error_flag_oe, .thermal_flag_o, .thermal_flag_oe,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .irq
  );

  lsd_host_model i_host (.serial_clk, .serial_in, .latch_strobe, .serial_out);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    d = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(what, rd, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // First listed group of each flow takes serial_in
  function automatic logic [23:0] flow_map(input int f, input logic [23:0] v);
    int ord [4][3] = '{'{0, 1, 2}, '{1, 2, 0}, '{2, 0, 1}, '{0, 2, 1}};
    flow_map = 24'h0;
    for (int k = 0; k < 3; k++) flow_map[ord[f][k]*8 +: 8] = v[k*8 +: 8];
  endfunction

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    detect_mode_pin = 1'b0;
    red_group_enable_n = 1'b1;
    green_group_enable_n = 1'b1;
    blue_group_enable_n = 1'b1;
    gradual_turn_on = 1'b0;
    {flow_select_1, flow_select_0} = 2'h0;
    fault_short_gnd = 24'h0;
    fault_short_supply = 24'h0;
    fault_open = 24'h0;
    over_temp = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    cyc(4);
    reset <= 1'b0;
    rd_chk("status", `LSD_OFS_IRQ_STATUS, 32'h0);
    rd_chk("storage", `LSD_OFS_STORAGE, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    for (int f = 3; f >= 0; f--) begin
      {flow_select_1, flow_select_0} <= 2'(f);
      cyc(4);
      i_host.shift24(PATTERN, seen);
      i_host.pulse_latch();
      rd_chk("flow storage", `LSD_OFS_STORAGE, {8'h0, flow_map(f, PATTERN)});
      rd_chk("flow mode", `LSD_OFS_MODE, 32'(f) << 2);
    end
    // Same flow again: the last frame must come out unchanged for a cascaded part
    i_host.shift24(24'h0, seen);
    chk("cascade out", {8'h0, seen}, {8'h0, PATTERN});
    chk("sinks gated", {8'h0, sink_on}, 32'h0);
    red_group_enable_n <= 1'b0;
    cyc(5);
    chk("red only", {8'h0, sink_on}, {16'h0, PATTERN[7:0]});
    // Interrupt raise, mask, clear
    rd_chk("latch event", `LSD_OFS_IRQ_STATUS, 32'h1);
    wr(`LSD_OFS_IRQ_ENABLE, 32'h1);
    rd_chk("enable", `LSD_OFS_IRQ_ENABLE, 32'h1);
    cyc(2);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(`LSD_OFS_IRQ_ENABLE, 32'h0);
    cyc(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`LSD_OFS_IRQ_CLEAR, 32'h1);
    rd_chk("cleared", `LSD_OFS_IRQ_STATUS, 32'h0);
    wr(`LSD_OFS_IRQ_ENABLE, 32'hf);
    // Gradual turn-on of the red group
    red_group_enable_n <= 1'b1;
    gradual_turn_on <= 1'b1;
    cyc(5);
    red_group_enable_n <= 1'b0;
    cyc(6);
    chk("late sink early", {31'h0, sink_on[7]}, 32'h0);
    cyc(40);
    chk("staggered on", {24'h0, sink_on[7:0]}, {24'h0, PATTERN[7:0]});
    gradual_turn_on <= 1'b0;
    green_group_enable_n <= 1'b0;
    blue_group_enable_n <= 1'b0;
    cyc(5);
    chk("all on", {8'h0, sink_on}, {8'h0, PATTERN});
    // Detection by pin
    fault_short_gnd <= 24'h000008;
    fault_short_supply <= 24'h001000;
    fault_open <= 24'h100000;
    detect_mode_pin <= 1'b1;
    cyc(4);
    rd_chk("detect mode", `LSD_OFS_MODE, 32'h3);
    i_host.pulse_latch();
    chk("error flag", {31'h0, error_flag_oe}, 32'h1);
    rd_chk("detect status", `LSD_OFS_IRQ_STATUS, 32'h6);
    chk("irq fault", {31'h0, irq}, 32'h1);
    rd_chk("storage kept", `LSD_OFS_STORAGE, {8'h0, PATTERN});
    i_host.shift24(24'h0, seen);
    chk("results out", {8'h0, seen}, 32'h101008);
    over_temp <= 1'b1;
    cyc(4);
    chk("thermal flag", {31'h0, thermal_flag_oe}, 32'h1);
    chk("flag levels and resp", {29'h0, error_flag_o, thermal_flag_o, hresp}, 32'h0);
    rd_chk("thermal status", `LSD_OFS_IRQ_STATUS, 32'he);
    detect_mode_pin <= 1'b0;
    over_temp <= 1'b0;
    cyc(4);
    rd_chk("normal mode", `LSD_OFS_MODE, 32'h0);
    // Enter then leave detection by command sequence
    for (int n = 0; n < 2; n++) begin
      red_group_enable_n <= 1'b1;
      cyc(4);
      i_host.set_latch(1'b1);
      @(posedge clk_sys);
      red_group_enable_n <= 1'b0;
      cyc(4);
      i_host.set_latch(1'b0);
      rd_chk("command mode", `LSD_OFS_MODE, 32'(1 - n));
    end
    conclude();
  end
endmodule // lsd_top_tb
